// ### design/softstart_pkg.sv
// Shared constants of the start-up and soft-start sequencer.
// Assumes a 50 MHz system clock and a coarse timebase tick of 100 us.
package softstart_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ         = 50_000_000;
  localparam int TICK_US        = 100;
  localparam int TICK_CYCLES    = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int NVM_CHECK_US   = 5000;
  localparam int MIN_DELAY_US   = 2000;
  localparam int MS_US          = 1000;
  localparam logic [9:0] NVM_TICKS = 10'(NVM_CHECK_US / TICK_US);
  localparam logic [9:0] MIN_DELAY_TICKS = 10'(MIN_DELAY_US / TICK_US);
  localparam logic [9:0] MS_TICKS = 10'(MS_US / TICK_US);

  // ------------------------------------------------------------------
  // Strap levels seen by the pin measurement front end
  // ------------------------------------------------------------------
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_RES  = 2'h3;

  localparam logic [4:0] SS_LAST_INDEX    = 5'h1E;
  localparam logic [4:0] SS_PART_GROUP    = 5'h03;
  localparam logic [4:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_SPLIT_INDEX = 5'h0F;
  localparam logic [4:0] TRIM_A_INDEX     = 5'h19;
  localparam logic [4:0] VSET_LAST_INDEX  = 5'h18;
  localparam logic [4:0] TRIM_LAST_INDEX  = 5'h1A;
  localparam logic [6:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_LOW_DV      = 7'h2D;
  localparam logic [6:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_HIGH_DV     = 7'h6C;
  localparam logic [11:0] VOUT_DEFAULT_MV = 12'h258;
  localparam logic [12:0] VOUT_MAX_MV     = 13'h0E10;

  // ------------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CUSTOM = 8'h04;
  localparam logic [7:0] REG_PGDLY  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_VREF   = 8'h10;
  localparam int CTRL_STORE_BIT   = 0;
  localparam int CTRL_RESTORE_BIT = 1;
  localparam int CUST_DELAY_LSB   = 0;
  localparam int CUST_RAMP_LSB    = 10;
  localparam int CUST_PGSEP_BIT   = 30;
  localparam int CUST_USE_BIT     = 31;
  localparam logic [31:0] CUSTOM_RESET = 32'h0000_0000;
  localparam logic [9:0]  PGDLY_RESET  = 10'h000;

endpackage

// ### design/tick_timer.sv
// Free-running prescaler giving a one-cycle tick every CYCLES clocks.
// Assumes a single clock and an asynchronous active-high reset.
module tick_timer #(
  parameter int CYCLES = 5000
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  always_comb begin
    tick = (cnt_reg == 16'(CYCLES - 1));
    cnt_next = tick ? 16'h0000 : cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ### design/strap_decode.sv
// Decodes soft-start and output-voltage straps into timings and target.
// Assumes the front end reports each pin as a level or a resistor index.
module strap_decode (
  input  wire logic [1:0]  ss_code,
  input  wire logic [4:0]  ss_index,
  input  wire logic [1:0]  vsel_a_code,
  input  wire logic [4:0]  vsel_a_index,
  input  wire logic [1:0]  vsel_b_code,
  input  wire logic [4:0]  vsel_b_index,
  output logic      [9:0]  delay_ticks,
  output logic      [9:0]  ramp_ticks,
  output logic             undervoltage_lockout_threshold_high,
  output logic      [11:0] target_mv,
  output logic             trim_mode
);
  import softstart_pkg::*;

  localparam logic [4:0] RAMP_MS [4] = '{5'd2, 5'd5, 5'd10, 5'd20};
  localparam logic [4:0] GRP_MS [7] = '{5'd5, 5'd10, 5'd20, 5'd2,
                                        5'd5, 5'd10, 5'd20};
  localparam logic [4:0] HEAD_DLY [3] = '{5'd0, 5'd2, 5'd2};
  localparam logic [11:0] GRID_MV [9] = '{12'd600, 12'd800, 12'd1000,
                                          12'd1200, 12'd1500, 12'd1800,
                                          12'd2500, 12'd3300, 12'd3600};
  localparam logic [11:0] TRIM_MV [27] = '{
    12'd700, 12'd752, 12'd758, 12'd765, 12'd772, 12'd790, 12'd800,
    12'd821, 12'd834, 12'd848, 12'd880, 12'd899, 12'd919, 12'd965,
    12'd991, 12'd1000, 12'd1100, 12'd1158, 12'd1200, 12'd1250,
    12'd1500, 12'd1669, 12'd1800, 12'd2295, 12'd2506, 12'd3300,
    12'd3600};

  function automatic logic [9:0] to_ticks(input logic [4:0] ms);
    return 10'(ms * MS_TICKS);
  endfunction

  logic [4:0]  ss_idx;
  logic [4:0]  k;
  logic [4:0]  ia;
  logic [4:0]  ib;
  logic [12:0] res_mv;

  // Soft-start strap and resistor table
  always_comb begin
    ss_idx = (ss_index > SS_LAST_INDEX) ? SS_LAST_INDEX : ss_index;
    k = ss_idx - SS_PART_GROUP;
    undervoltage_lockout_threshold_high = 1'b0;
    unique case (ss_code)
      LVL_LOW: begin
        delay_ticks = to_ticks(5'd2);
        ramp_ticks  = to_ticks(5'd2);
      end
      LVL_OPEN: begin
        delay_ticks = to_ticks(5'd5);
        ramp_ticks  = to_ticks(5'd5);
      end
      LVL_HIGH: begin
        delay_ticks = to_ticks(5'd10);
        ramp_ticks  = to_ticks(5'd10);
      end
      default: begin
        undervoltage_lockout_threshold_high = (ss_idx >= UNDERVOLTAGE_LOCKOUT_THRESHOLD_SPLIT_INDEX);
        if (ss_idx < SS_PART_GROUP) begin
          delay_ticks = to_ticks(HEAD_DLY[ss_idx[1:0]]);
          ramp_ticks  = to_ticks(RAMP_MS[ss_idx[1:0]]);
        end else begin
          delay_ticks = to_ticks(GRP_MS[k[4:2]]);
          ramp_ticks  = to_ticks(RAMP_MS[k[1:0]]);
        end
      end
    endcase
  end

  // Output voltage straps, resistor pair and trim mode
  always_comb begin
    ia = (vsel_a_index > VSET_LAST_INDEX) ? VSET_LAST_INDEX : vsel_a_index;
    ib = (vsel_b_index > VSET_LAST_INDEX) ? VSET_LAST_INDEX : vsel_b_index;
    res_mv = 13'(10 * (25 * ib + ia));
    trim_mode = (vsel_a_code == LVL_RES) &&
                (vsel_a_index == TRIM_A_INDEX);
    if (trim_mode) begin
      target_mv = TRIM_MV[(vsel_b_index > TRIM_LAST_INDEX) ?
                          TRIM_LAST_INDEX : vsel_b_index];
    end else if (vsel_a_code == LVL_RES && vsel_b_code == LVL_RES) begin
      target_mv = (res_mv > VOUT_MAX_MV) ? VOUT_MAX_MV[11:0] : res_mv[11:0];
    end else if (vsel_a_code != LVL_RES && vsel_b_code != LVL_RES) begin
      target_mv = GRID_MV[4'(vsel_b_code * 3 + vsel_a_code)];
    end else begin
      target_mv = VOUT_DEFAULT_MV;
    end
  end
endmodule

// ### design/softstart_seq.sv
// Start-up sequencer and soft-start ramp generator with Wishbone registers.
// Assumes strap inputs are stable, synchronous, and measured by a front end.
module softstart_seq
  import softstart_pkg::*;
#(
  parameter int TICK_CYC = softstart_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        enable_in,
  input  wire logic [1:0]  ss_code,
  input  wire logic [4:0]  ss_index,
  input  wire logic [1:0]  vout_select_pin_a_code,
  input  wire logic [4:0]  vout_select_pin_a_index,
  input  wire logic [1:0]  vout_select_pin_b_code,
  input  wire logic [4:0]  vout_select_pin_b_index,
  output logic      [11:0] vout_ref_mv,
  output logic             ready,
  output logic             ramp_active,
  output logic             power_good_output,
  output logic      [6:0]  undervoltage_lockout_threshold
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_NVM, ST_PINS, ST_READY, ST_DELAY, ST_RAMP, ST_ON
  } seq_state_e;

  seq_state_e  state_reg;
  seq_state_e  state_next;
  logic [9:0]  cnt_reg;
  logic [9:0]  cnt_next;
  logic [11:0] ref_reg;
  logic [11:0] ref_next;
  logic [11:0] step_reg;
  logic [11:0] step_next;
  logic        pg_reg;
  logic        pg_next;
  logic [31:0] cust_reg;
  logic [31:0] cust_next;
  logic [31:0] saved_reg;
  logic [31:0] saved_next;
  logic [9:0]  pgd_reg;
  logic [9:0]  pgd_next;
  logic [9:0]  saved_pgd_reg;
  logic [9:0]  saved_pgd_next;
  logic [9:0]  ss_delay_reg;
  logic [9:0]  ss_delay_next;
  logic [9:0]  ss_ramp_reg;
  logic [9:0]  ss_ramp_next;
  logic        undervoltage_lockout_threshold_reg;
  logic        undervoltage_lockout_threshold_next;
  logic        trim_reg;
  logic        trim_next;
  logic [11:0] target_reg;
  logic [11:0] target_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;

  logic        tick;
  logic [9:0]  dec_delay;
  logic [9:0]  dec_ramp;
  logic        dec_undervoltage_lockout_threshold;
  logic [11:0] dec_target;
  logic        dec_trim;
  logic        bus_ok;
  logic        access;
  logic        wr;
  logic        use_cust;
  logic [9:0]  cfg_delay;
  logic [9:0]  eff_delay;
  logic [9:0]  eff_ramp;
  logic [9:0]  pg_delay;
  logic [9:0]  cnt_inc;
  logic [31:0] wmask;

  // ------------------------------------------------------------------
  // Timebase and strap decoding
  // ------------------------------------------------------------------
  tick_timer #(
    .CYCLES (TICK_CYC)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  strap_decode u_dec (
    .ss_code      (ss_code),
    .ss_index     (ss_index),
    .vsel_a_code  (vout_select_pin_a_code),
    .vsel_a_index (vout_select_pin_a_index),
    .vsel_b_code  (vout_select_pin_b_code),
    .vsel_b_index (vout_select_pin_b_index),
    .delay_ticks  (dec_delay),
    .ramp_ticks   (dec_ramp),
    .undervoltage_lockout_threshold_high    (dec_undervoltage_lockout_threshold),
    .target_mv    (dec_target),
    .trim_mode    (dec_trim)
  );

  // ------------------------------------------------------------------
  // Effective timing
  // ------------------------------------------------------------------
  always_comb begin
    use_cust = cust_reg[CUST_USE_BIT];
    cfg_delay = use_cust ? cust_reg[CUST_DELAY_LSB +: 10]
                         : ss_delay_reg;
    eff_delay = (cfg_delay < MIN_DELAY_TICKS) ? MIN_DELAY_TICKS
                                              : cfg_delay;
    eff_ramp = use_cust ? cust_reg[CUST_RAMP_LSB +: 10]
                        : ss_ramp_reg;
    pg_delay = cust_reg[CUST_PGSEP_BIT] ? pgd_reg : eff_ramp;
    cnt_inc = cnt_reg + 10'h001;
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // ------------------------------------------------------------------
  // Bus and sequencer next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    ref_next       = ref_reg;
    step_next      = step_reg;
    pg_next        = pg_reg;
    cust_next      = cust_reg;
    saved_next     = saved_reg;
    pgd_next       = pgd_reg;
    saved_pgd_next = saved_pgd_reg;
    ss_delay_next  = ss_delay_reg;
    ss_ramp_next   = ss_ramp_reg;
    undervoltage_lockout_threshold_next      = undervoltage_lockout_threshold_reg;
    trim_next      = trim_reg;
    target_next    = target_reg;
    bus_ok = (state_reg != ST_NVM) && (state_reg != ST_PINS);
    access = wb_cyc_i && wb_stb_i && !ack_reg;
    wr = access && wb_we_i && bus_ok;
    ack_next = access;
    dat_next = 32'h0000_0000;

    if (access && !wb_we_i && bus_ok) begin
      unique case (wb_adr_i)
        REG_CUSTOM: dat_next = cust_reg;
        REG_PGDLY:  dat_next = {22'h000000, pgd_reg};
        REG_STATUS: dat_next = {4'h0, target_reg, 9'h000, undervoltage_lockout_threshold_reg,
                                trim_reg, pg_reg, bus_ok, 3'(state_reg)};
        REG_VREF:   dat_next = {20'h00000, ref_reg};
        default:    dat_next = 32'h0000_0000;
      endcase
    end
    if (wr && wb_adr_i == REG_CUSTOM) begin
      cust_next = (cust_reg & ~wmask) | (wb_dat_i & wmask);
    end
    if (wr && wb_adr_i == REG_PGDLY) begin
      pgd_next = (pgd_reg & ~wmask[9:0]) | (wb_dat_i[9:0] & wmask[9:0]);
    end
    if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0] &&
        wb_dat_i[CTRL_STORE_BIT]) begin
      saved_next = cust_reg;
      saved_pgd_next = pgd_reg;
    end

    unique case (state_reg)
      ST_NVM: begin
        if (tick) begin
          cnt_next = cnt_inc;
          if (cnt_inc >= NVM_TICKS) begin
            cust_next = saved_reg;
            pgd_next = saved_pgd_reg;
            cnt_next = 10'h000;
            state_next = ST_PINS;
          end
        end
      end
      ST_PINS: begin
        ss_delay_next = dec_delay;
        ss_ramp_next = dec_ramp;
        undervoltage_lockout_threshold_next = dec_undervoltage_lockout_threshold;
        trim_next = dec_trim;
        target_next = dec_target;
        state_next = ST_READY;
      end
      ST_READY: begin
        if (enable_in) begin
          cnt_next = 10'h000;
          state_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!enable_in) begin
          state_next = ST_READY;
        end else if (tick) begin
          cnt_next = cnt_inc;
          if (cnt_inc >= eff_delay) begin
            cnt_next = 10'h000;
            ref_next = 12'h000;
            if (eff_ramp == 10'h000) begin
              ref_next = target_reg;
              state_next = ST_ON;
            end else begin
              step_next = 12'(target_reg / eff_ramp);
              state_next = ST_RAMP;
            end
          end
        end
      end
      ST_RAMP: begin
        if (!enable_in) begin
          ref_next = 12'h000;
          state_next = ST_READY;
        end else if (tick) begin
          cnt_next = cnt_inc;
          if (cnt_inc >= eff_ramp) begin
            ref_next = target_reg;
            cnt_next = 10'h000;
            state_next = ST_ON;
          end else begin
            ref_next = ref_reg + step_reg;
          end
        end
      end
      ST_ON: begin
        if (!enable_in) begin
          ref_next = 12'h000;
          pg_next = 1'b0;
          state_next = ST_READY;
        end else if (tick && !pg_reg) begin
          cnt_next = cnt_inc;
          if (cnt_inc >= pg_delay) begin
            pg_next = 1'b1;
          end
        end else if (pg_delay == 10'h000) begin
          pg_next = 1'b1;
        end
      end
    endcase

    if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0] &&
        wb_dat_i[CTRL_RESTORE_BIT]) begin
      state_next = ST_NVM;
      cnt_next = 10'h000;
      ref_next = 12'h000;
      pg_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_NVM;
      cnt_reg       <= 10'h000;
      ref_reg       <= 12'h000;
      step_reg      <= 12'h000;
      pg_reg        <= 1'b0;
      cust_reg      <= CUSTOM_RESET;
      saved_reg     <= CUSTOM_RESET;
      pgd_reg       <= PGDLY_RESET;
      saved_pgd_reg <= PGDLY_RESET;
      ss_delay_reg  <= 10'h000;
      ss_ramp_reg   <= 10'h000;
      undervoltage_lockout_threshold_reg      <= 1'b0;
      trim_reg      <= 1'b0;
      target_reg    <= 12'h000;
      ack_reg       <= 1'b0;
      dat_reg       <= 32'h0000_0000;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      ref_reg       <= ref_next;
      step_reg      <= step_next;
      pg_reg        <= pg_next;
      cust_reg      <= cust_next;
      saved_reg     <= saved_next;
      pgd_reg       <= pgd_next;
      saved_pgd_reg <= saved_pgd_next;
      ss_delay_reg  <= ss_delay_next;
      ss_ramp_reg   <= ss_ramp_next;
      undervoltage_lockout_threshold_reg      <= undervoltage_lockout_threshold_next;
      trim_reg      <= trim_next;
      target_reg    <= target_next;
      ack_reg       <= ack_next;
      dat_reg       <= dat_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_comb begin
    wb_ack_o = ack_reg;
    wb_dat_o = dat_reg;
    vout_ref_mv = ref_reg;
    ready = (state_reg != ST_NVM) && (state_reg != ST_PINS);
    ramp_active = (state_reg == ST_RAMP);
    power_good_output = pg_reg;
    undervoltage_lockout_threshold = undervoltage_lockout_threshold_reg ? UNDERVOLTAGE_LOCKOUT_THRESHOLD_HIGH_DV : UNDERVOLTAGE_LOCKOUT_THRESHOLD_LOW_DV;
  end
endmodule

// ### verif/softstart_seq_monitor.sv
// Checker for the start-up and soft-start sequencer top ports.
// Assumes one clock domain and an asynchronous active-high reset.
module softstart_seq_monitor #(
  parameter int TICK_CYC = 5000
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        enable_in,
  input wire logic [11:0] vout_ref_mv,
  input wire logic        ready,
  input wire logic        ramp_active,
  input wire logic        power_good_output,
  input wire logic [6:0]  undervoltage_lockout_threshold
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Cycles spent with enable high while ready
  // ------------------------------------------------------------------
  localparam int MIN_CYC = 19 * TICK_CYC;
  logic [23:0] en_cnt_reg;
  logic [23:0] en_cnt_next;
  always_comb begin
    en_cnt_next = en_cnt_reg;
    if (!enable_in || !ready) begin
      en_cnt_next = 24'h000000;
    end else if (en_cnt_reg != 24'hFFFFFF) begin
      en_cnt_next = en_cnt_reg + 24'h000001;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_cnt_reg <= 24'h000000;
    end else begin
      en_cnt_reg <= en_cnt_next;
    end
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
  property p_read_refused;
    wb_ack_o && !wb_we_i && !$past(ready) |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_read_refused: assert property (p_read_refused)
    else $error("read answered before ready");
  property p_idle_off;
    !ready && !$past(ready) |->
      vout_ref_mv == 12'h000 && !ramp_active && !power_good_output;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("output active before ready");
  property p_monotonic;
    ramp_active && $past(ramp_active) |-> vout_ref_mv >= $past(vout_ref_mv);
  endproperty
  a_monotonic: assert property (p_monotonic)
    else $error("ramp reversed");
  property p_min_delay;
    $rose(ramp_active) |-> en_cnt_reg >= MIN_CYC;
  endproperty
  a_min_delay: assert property (p_min_delay)
    else $error("ramp started early");
  property p_enable_drop;
    ready && !enable_in |=> !ramp_active ##1 !power_good_output;
  endproperty
  a_enable_drop: assert property (p_enable_drop)
    else $error("output kept after enable low");
  property p_undervoltage_lockout_threshold_held;
    ready && $past(ready) |-> $stable(undervoltage_lockout_threshold);
  endproperty
  a_undervoltage_lockout_threshold_held: assert property (p_undervoltage_lockout_threshold_held)
    else $error("threshold changed while ready");
  property p_pg_after_ramp;
    $rose(power_good_output) |-> !ramp_active && vout_ref_mv != 12'h000;
  endproperty
  a_pg_after_ramp: assert property (p_pg_after_ramp)
    else $error("power good during ramp");
  c_ramp: cover property ($rose(ramp_active));
  c_pg: cover property ($rose(power_good_output));
  c_refused: cover property (wb_ack_o && !ready);
endmodule

bind softstart_seq softstart_seq_monitor #(.TICK_CYC(TICK_CYC))
  i_softstart_seq_monitor (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .enable_in(enable_in), .vout_ref_mv(vout_ref_mv),
  .ready(ready), .ramp_active(ramp_active),
  .power_good_output(power_good_output),
  .undervoltage_lockout_threshold(undervoltage_lockout_threshold));

// ### verif/host_enable_model.sv
// Host model driving the enable line of the sequencer.
// Assumes the system clock runs from time zero.
module host_enable_model #(
  parameter int SETTLE = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic go,
  output logic      enable_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int settle_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_cnt <= 0;
      enable_in  <= 1'b0;
    end else begin
      if (settle_cnt < SETTLE) begin
        settle_cnt <= settle_cnt + 1;
      end
      // Enable only after the clock has run stable for a while
      enable_in <= go && (settle_cnt >= SETTLE);
    end
  end
endmodule

// ### verif/softstart_seq_test.sv
// Testbench for the start-up and soft-start sequencer.
// Assumes the monitor is bound and the host model drives enable.
module softstart_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  import softstart_pkg::*;
  localparam int T = 20;
  logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, go, enable_in;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [1:0]  ss_code, vout_select_pin_a_code, vout_select_pin_b_code;
  logic [4:0]  ss_index, vout_select_pin_a_index, vout_select_pin_b_index;
  logic [11:0] vout_ref_mv;
  logic        ready, ramp_active, power_good_output;
  logic [6:0]  undervoltage_lockout_threshold;
  int err_count = 0;
  int tests_run = 0;
  int n;
  int dl[3] = '{0, 5, 40};
  softstart_seq #(.TICK_CYC(T)) i_softstart_seq (.clk, .rst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .enable_in, .ss_code, .ss_index, .vout_select_pin_a_code,
    .vout_select_pin_a_index, .vout_select_pin_b_code,
    .vout_select_pin_b_index, .vout_ref_mv, .ready, .ramp_active,
    .power_good_output, .undervoltage_lockout_threshold);
  host_enable_model #(.SETTLE(16)) i_host_enable_model (.clk, .rst, .go,
    .enable_in);
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic near(input int c, input int k);
    check(32'(c >= (k - 1) * T && c <= (k + 1) * T + 8), 32'h1);
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int c;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (wb_ack_o !== 1'b1 && c < 50);
    if (c >= 50) begin
      err_count++;
      test_done();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Selector: 0 ready, 1 ramp on, 2 power good, 3 ramp off
  task automatic wait_for(input int w, output int c);
    logic s;
    c = 0;
    do begin
      @(posedge clk);
      c++;
      s = (w == 0) ? ready : (w == 1) ? ramp_active :
          (w == 2) ? power_good_output : !ramp_active;
    end while (s !== 1'b1 && c < 20000);
    if (c >= 20000) begin
      err_count++;
      test_done();
    end
  endtask
  task automatic run(input int d, input int r, input int p,
                     input logic [11:0] tgt);
    int c;
    go <= 1'b1;
    wait_for(1, c);
    near(c, (d < 20) ? 20 : d);
    wait_for(3, c);
    near(c, r);
    check(32'(vout_ref_mv), 32'(tgt));
    wait_for(2, c);
    near(c, p);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(vout_ref_mv), 32'h0);
  endtask
  task automatic restore_wait;
    wb(1'b1, REG_CTRL, 32'h2, q);
    repeat (2) @(posedge clk);
    check(32'(ready), 32'h0);
    wait_for(0, n);
    near(n, 50);
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, go} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    {ss_code, vout_select_pin_a_code, vout_select_pin_b_code} = 6'h00;
    {ss_index, vout_select_pin_a_index, vout_select_pin_b_index} = 15'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    go <= 1'b1;
    wb(1'b1, REG_CUSTOM, 32'h8000_0005, q);
    wb(1'b0, REG_CUSTOM, 32'h0, q);
    check(q, 32'h0);
    // Keep enable up for a while inside the memory check
    repeat (20) @(posedge clk);
    go <= 1'b0;
    wait_for(0, n);
    near(n + 26, 50);
    wb(1'b0, REG_STATUS, 32'h0, q);
    check(32'(q[3:0]), 32'hA);
    wb(1'b0, REG_CUSTOM, 32'h0, q);
    check(q, 32'h0);
    wb(1'b0, 8'h3C, 32'h0, q);
    check(q, 32'h0);
    check(32'(undervoltage_lockout_threshold), 32'h2D);
    run(20, 20, 20, 12'h258);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, REG_PGDLY, 32'h7, q);
      wb(1'b1, REG_CUSTOM,
         {1'b1, 1'(i == 2), 10'h000, 10'h003, 10'(dl[i])}, q);
      run(dl[i], 3, (i == 2) ? 7 : 3, 12'h258);
    end
    wb(1'b0, REG_CUSTOM, 32'h0, q);
    check(q, 32'hC000_0C28);
    ss_code <= 2'h3;
    ss_index <= 5'h14;
    {vout_select_pin_a_code, vout_select_pin_b_code} <= 4'hF;
    vout_select_pin_a_index <= 5'h19;
    vout_select_pin_b_index <= 5'h1A;
    repeat (2) @(posedge clk);
    check(32'(undervoltage_lockout_threshold), 32'h2D);
    restore_wait();
    ss_index <= 5'h00;
    check(32'(undervoltage_lockout_threshold), 32'h6C);
    wb(1'b0, REG_STATUS, 32'h0, q);
    check({20'h0, q[27:16]}, 32'hE10);
    check(32'(q[5]), 32'h1);
    run(50, 50, 50, 12'hE10);
    vout_select_pin_b_index <= 5'h00;
    restore_wait();
    wb(1'b0, REG_STATUS, 32'h0, q);
    check({20'h0, q[27:16]}, 32'h2BC);
    // Stored copy reloads on restore; strap high with level vout pins
    wb(1'b1, REG_CUSTOM, 32'h0000_0C05, q);
    wb(1'b1, REG_CTRL, 32'h1, q);
    ss_code <= 2'h2;
    {vout_select_pin_a_code, vout_select_pin_b_code} <= 4'h6;
    restore_wait();
    wb(1'b0, REG_CUSTOM, 32'h0, q);
    check(q, 32'h0000_0C05);
    run(100, 100, 100, 12'hCE4);
    test_done();
  end
endmodule
